// [src/pgps_top.v]
// Power-good, phase-shed and crowbar supervisor of a multiphase buck controller
`timescale 1ns/1ps
`default_nettype none
`include "pgps_consts.vh"

module pgps_top
#(
    parameter DELAY_STEP_CYC = `PGPS_DELAY_STEP_CYC
)
(
    input wire i_clk,
    input wire i_nrst,
    input wire i_ce,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    output wire [7:0] o_reg_rdata,
    input wire i_undervoltage_lockout_ok,
    input wire i_enable,
    input wire i_low_power_state_n,
    input wire i_soft_start_done,
    input wire i_below_release,
    input wire [7:0] i_output_sense_ref,
    input wire [7:0] i_voltage_id_code,
    input wire i_power_good_in,
    output reg o_power_good_out,
    output reg o_power_good_out_oe,
    output reg o_pwm_force_low,
    output reg o_shed_phase_disable_n,
    output reg o_main_phase_disable_n,
    output reg [7:0] o_phase_active,
    output reg [2:0] o_ilim_div
);

    localparam [3:0] ST_OFF = 4'b0001;
    localparam [3:0] ST_SOFT = 4'b0010;
    localparam [3:0] ST_DELAY = 4'b0100;
    localparam [3:0] ST_RUN = 4'b1000;
    localparam [19:0] STEP_CYC = DELAY_STEP_CYC[19:0];
    localparam integer BLANK_INT = `PGPS_BLANK_CYC;
    localparam [11:0] BLANK_CYC = BLANK_INT[11:0];

    // Returns {divisor, kept phase mask}; phase 1 is bit 0
    function [10:0] shed_lookup;
        input [2:0] cnt_m1;
        input [1:0] code;
        begin
            if (cnt_m1 == 3'd7)
                shed_lookup = (code == 2'b00) ? {3'd4, 8'h01} :
                              (code == 2'b01) ? {3'd4, 8'h11} : {3'd2, 8'h55};
            else if (cnt_m1 == 3'd5)
                shed_lookup = (code == 2'b00) ? {3'd4, 8'h01} :
                              (code == 2'b01) ? {3'd3, 8'h09} : {3'd2, 8'h15};
            else if (cnt_m1 == 3'd0)
                shed_lookup = {3'd1, 8'h01};
            else if (code == 2'b00)
                shed_lookup = {((cnt_m1 >= 3'd3) ? 3'd4 : cnt_m1 + 3'd1), 8'h01};
            else if (cnt_m1 == 3'd6 && code == 2'b01)
                shed_lookup = {3'd4, 8'h01};
            else
                shed_lookup = {3'd2, 8'h01};
        end
    endfunction

    // Mask of the phases running normally
    function [7:0] phase_mask;
        input [2:0] cnt_m1;
        begin
            phase_mask = 8'hFF >> (3'd7 - cnt_m1);
        end
    endfunction

    wire [7:0] shed_cfg;
    wire [7:0] ton_delay;
    wire [7:0] pg_high;
    wire [7:0] pg_low;
    wire [7:0] phase_cnt;
    wire [7:0] status;

    // Synchroniser: first stage feeds only the second
    reg [21:0] sync1_ff;
    reg [21:0] sync2_ff;
    wire [21:0] async_in = {i_undervoltage_lockout_ok, i_enable, i_low_power_state_n,
                            i_soft_start_done, i_below_release, i_power_good_in,
                            i_output_sense_ref, i_voltage_id_code};
    wire s_undervoltage_lockout_ok = sync2_ff[21];
    wire s_en = sync2_ff[20];
    wire s_lps_n = sync2_ff[19];
    wire s_ss_done = sync2_ff[18];
    wire s_below_rel = sync2_ff[17];
    wire s_pg_pin = sync2_ff[16];
    wire [7:0] s_sense = sync2_ff[15:8];
    wire [7:0] s_vid = sync2_ff[7:0];

    reg [3:0] state_ff;
    reg [3:0] nxt_state;
    reg [19:0] dly_cnt_ff;
    reg [19:0] nxt_dly_cnt;
    reg [11:0] blank_cnt_ff;
    reg [11:0] nxt_blank_cnt;
    reg [7:0] vid_prev_ff;
    reg crowbar_ff;
    reg nxt_crowbar;
    reg pg_ff;
    reg nxt_pg;

    wire enabled = s_undervoltage_lockout_ok & s_en;
    // Ignored while off: the previous-code register wakes at zero, and a
    // false change after reset would blank power good for a whole interval
    wire vid_changed = (state_ff != ST_OFF) && (s_vid != vid_prev_ff);
    wire blanking = (blank_cnt_ff != 12'h000);
    wire in_window = (s_sense <= pg_high) && (s_sense >= pg_low);
    wire no_cpu = (s_vid == `PGPS_VID_NO_CPU);
    // Four-bit sum, so code 7 gives eight steps instead of wrapping to zero
    wire [19:0] delay_cyc = STEP_CYC * {16'h0000, {1'b0, ton_delay[2:0]} + 4'd1};
    wire [10:0] shed_sel = shed_lookup(phase_cnt[2:0], shed_cfg[7:6]);

    assign status = {s_pg_pin, pg_ff, crowbar_ff, blanking, state_ff};

    pgps_regs u_regs
    (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_wr(i_reg_wr),
        .i_rd(i_reg_rd),
        .i_addr(i_reg_addr),
        .i_wdata(i_reg_wdata),
        .i_status(status),
        .o_rdata(o_reg_rdata),
        .o_shed_cfg(shed_cfg),
        .o_ton_delay(ton_delay),
        .o_pg_high(pg_high),
        .o_pg_low(pg_low),
        .o_phase_cnt(phase_cnt)
    );

    always @*
    begin
        nxt_state = state_ff;
        nxt_dly_cnt = dly_cnt_ff;
        case (state_ff)
            ST_OFF:
            begin
                if (enabled)
                    nxt_state = ST_SOFT;
            end
            ST_SOFT:
            begin
                if (s_ss_done)
                begin
                    nxt_state = ST_DELAY;
                    nxt_dly_cnt = delay_cyc;
                end
            end
            ST_DELAY:
            begin
                if (dly_cnt_ff <= 20'd1)
                    nxt_state = ST_RUN;
                else
                    nxt_dly_cnt = dly_cnt_ff - 20'd1;
            end
            ST_RUN: ;
            default: nxt_state = ST_OFF;
        endcase
        if (!enabled)
        begin
            nxt_state = ST_OFF;
            nxt_dly_cnt = 20'h00000;
        end
    end

    always @*
    begin
        // Any change outside the off state reloads, so blanking ends one interval after the last change
        if (vid_changed)
            nxt_blank_cnt = BLANK_CYC;
        else if (blanking)
            nxt_blank_cnt = blank_cnt_ff - 12'd1;
        else
            nxt_blank_cnt = blank_cnt_ff;

        // Trip on the programmed upper limit; release only on the low comparator
        if (s_below_rel)
            nxt_crowbar = 1'b0;
        else if (enabled && !blanking && !vid_changed && s_sense > pg_high)
            nxt_crowbar = 1'b1;
        else
            nxt_crowbar = crowbar_ff;

        // Blanking freezes the window result, not the hard overrides
        // Lockout drop pulls power good in the same cycle as enable low
        if (state_ff != ST_RUN || !enabled || no_cpu)
            nxt_pg = 1'b0;
        else if (blanking || vid_changed)
            nxt_pg = pg_ff;
        else
            nxt_pg = in_window;
    end

    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sync1_ff <= 22'h00_0000;
            sync2_ff <= 22'h00_0000;
            state_ff <= ST_OFF;
            dly_cnt_ff <= 20'h0_0000;
            blank_cnt_ff <= 12'h000;
            vid_prev_ff <= 8'h00;
            crowbar_ff <= 1'b0;
            pg_ff <= 1'b0;
            o_power_good_out <= 1'b0;
            o_power_good_out_oe <= 1'b1;
            o_pwm_force_low <= 1'b1;
            o_shed_phase_disable_n <= 1'b0;
            o_main_phase_disable_n <= 1'b0;
            o_phase_active <= 8'h00;
            o_ilim_div <= 3'd1;
        end
        else if (i_ce)
        begin
            sync1_ff <= async_in;
            sync2_ff <= sync1_ff;
            state_ff <= nxt_state;
            dly_cnt_ff <= nxt_dly_cnt;
            blank_cnt_ff <= nxt_blank_cnt;
            vid_prev_ff <= s_vid;
            crowbar_ff <= nxt_crowbar;
            pg_ff <= nxt_pg;
            // Open drain: pull low unless good
            o_power_good_out_oe <= ~nxt_pg;
            o_pwm_force_low <= nxt_crowbar | (nxt_state == ST_OFF);
            o_main_phase_disable_n <= (nxt_state != ST_OFF);
            o_shed_phase_disable_n <= (nxt_state != ST_OFF) & s_lps_n;
            if (nxt_state == ST_OFF)
                o_phase_active <= 8'h00;
            else if (!s_lps_n)
                o_phase_active <= shed_sel[7:0];
            else
                o_phase_active <= phase_mask(phase_cnt[2:0]);
            o_ilim_div <= s_lps_n ? 3'd1 : shed_sel[10:8];
        end
    end

endmodule // pgps_top
`default_nettype wire

// [shared/pgps_consts.vh]
// Constants of the power-good, phase-shed and crowbar supervisor
`ifndef PGPS_CONSTS_VH
`define PGPS_CONSTS_VH

// Clock and times
`define PGPS_CLK_KHZ 40000
`define PGPS_BLANK_US 100
`define PGPS_BLANK_CYC ((`PGPS_BLANK_US * `PGPS_CLK_KHZ) / 1000)
`define PGPS_DELAY_STEP_US 500
`define PGPS_DELAY_STEP_CYC ((`PGPS_DELAY_STEP_US * `PGPS_CLK_KHZ) / 1000)

// Register offsets
`define PGPS_ADDR_SHED_CFG 8'h03
`define PGPS_ADDR_TON_DELAY 8'hD4
`define PGPS_ADDR_PG_HIGH 8'hE8
`define PGPS_ADDR_PG_LOW 8'hE9
`define PGPS_ADDR_PHASE_CNT 8'hEA
`define PGPS_ADDR_STATUS 8'hEB

// Field positions
`define PGPS_SHED_CODE_HI 7
`define PGPS_SHED_CODE_LO 6
`define PGPS_DELAY_CODE_HI 2
`define PGPS_DELAY_CODE_LO 0
`define PGPS_PHASE_CNT_HI 2
`define PGPS_PHASE_CNT_LO 0

// Reset values
`define PGPS_RST_SHED_CFG 8'h00
`define PGPS_RST_TON_DELAY 8'h03
`define PGPS_RST_PG_HIGH 8'hC0
`define PGPS_RST_PG_LOW 8'h40
`define PGPS_RST_PHASE_CNT 8'h07

// Voltage-ID code that means no processor present
`define PGPS_VID_NO_CPU 8'h00

`endif

// [src/pgps_regs.v]
// Register file of the supervisor with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "pgps_consts.vh"

module pgps_regs
(
    input wire i_clk,
    input wire i_nrst,
    input wire i_ce,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire [7:0] i_status,
    output reg [7:0] o_rdata,
    output reg [7:0] o_shed_cfg,
    output reg [7:0] o_ton_delay,
    output reg [7:0] o_pg_high,
    output reg [7:0] o_pg_low,
    output reg [7:0] o_phase_cnt
);

    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_shed_cfg <= `PGPS_RST_SHED_CFG;
            o_ton_delay <= `PGPS_RST_TON_DELAY;
            o_pg_high <= `PGPS_RST_PG_HIGH;
            o_pg_low <= `PGPS_RST_PG_LOW;
            o_phase_cnt <= `PGPS_RST_PHASE_CNT;
            o_rdata <= 8'h00;
        end
        else if (i_ce)
        begin
            if (i_wr)
            begin
                case (i_addr)
                    `PGPS_ADDR_SHED_CFG: o_shed_cfg <= i_wdata;
                    `PGPS_ADDR_TON_DELAY: o_ton_delay <= {5'h00, i_wdata[2:0]};
                    `PGPS_ADDR_PG_HIGH: o_pg_high <= i_wdata;
                    `PGPS_ADDR_PG_LOW: o_pg_low <= i_wdata;
                    `PGPS_ADDR_PHASE_CNT: o_phase_cnt <= {5'h00, i_wdata[2:0]};
                    default: ;
                endcase
            end
            if (i_rd)
            begin
                case (i_addr)
                    `PGPS_ADDR_SHED_CFG: o_rdata <= o_shed_cfg;
                    `PGPS_ADDR_TON_DELAY: o_rdata <= o_ton_delay;
                    `PGPS_ADDR_PG_HIGH: o_rdata <= o_pg_high;
                    `PGPS_ADDR_PG_LOW: o_rdata <= o_pg_low;
                    `PGPS_ADDR_PHASE_CNT: o_rdata <= o_phase_cnt;
                    `PGPS_ADDR_STATUS: o_rdata <= i_status;
                    default: o_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule // pgps_regs
`default_nettype wire

// [testbench/pgps_drv_model.sv]
// Far-side model: pulled-up power-good wire
`timescale 1ns/1ps
`default_nettype none
module pgps_drv_model
(
    input wire logic i_pg_oe,
    output logic o_pg_wire
);
    // Pull-up wins unless the supervisor pulls low
    assign o_pg_wire = i_pg_oe ? 1'b0 : 1'b1;
endmodule // pgps_drv_model
`default_nettype wire

// [testbench/pgps_checker.sv]
// Port checker of the supervisor
`timescale 1ns/1ps
`default_nettype none
`include "pgps_consts.vh"
module pgps_checker
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_undervoltage_lockout_ok,
    input wire logic i_enable,
    input wire logic i_low_power_state_n,
    input wire logic i_soft_start_done,
    input wire logic i_below_release,
    input wire logic [7:0] i_output_sense_ref,
    input wire logic [7:0] i_voltage_id_code,
    input wire logic o_power_good_out_oe,
    input wire logic o_pwm_force_low,
    input wire logic o_shed_phase_disable_n,
    input wire logic o_main_phase_disable_n,
    input wire logic [2:0] o_ilim_div
);
    logic [7:0] hi_ff;
    logic [7:0] lo_ff;
    logic [12:0] quiet_ff;
    wire run = i_enable && i_undervoltage_lockout_ok;
    wire quiet = quiet_ff > 13'h0FB0;
    // Shadow limits; the crowbar trip check waits out any code change
    always_ff @(posedge i_clk or negedge i_nrst)
        if (!i_nrst)
        begin
            hi_ff <= `PGPS_RST_PG_HIGH;
            lo_ff <= `PGPS_RST_PG_LOW;
            quiet_ff <= 13'h0000;
        end
        else
        begin
            if (i_ce && i_reg_wr && i_reg_addr == `PGPS_ADDR_PG_HIGH)
                hi_ff <= i_reg_wdata;
            if (i_ce && i_reg_wr && i_reg_addr == `PGPS_ADDR_PG_LOW)
                lo_ff <= i_reg_wdata;
            if ($changed(i_voltage_id_code))
                quiet_ff <= 13'h0000;
            else if (!quiet_ff[12])
                quiet_ff <= quiet_ff + 13'h0001;
        end
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);
    a_off_forced:
    assert property (!run [*3] |=> o_power_good_out_oe && o_pwm_force_low
        && !o_shed_phase_disable_n && !o_main_phase_disable_n) else $error("not off");
    a_shed_low:
    assert property (!i_low_power_state_n [*3] |=> !o_shed_phase_disable_n)
        else $error("shed disable not low");
    a_blank_hold:
    assert property (run [*4] ##0 ($changed(i_voltage_id_code) && i_voltage_id_code != 8'h00
        && !o_power_good_out_oe) |=> ##4 !o_power_good_out_oe [*8]) else $error("not blanked");
    a_crowbar_trip:
    assert property ((i_output_sense_ref > hi_ff && !i_below_release && quiet) [*3]
        |=> o_pwm_force_low) else $error("crowbar missed");
    a_crowbar_release:
    assert property ((i_below_release && run) [*5] |=> !o_pwm_force_low)
        else $error("crowbar held");
    a_pg_rise_cause:
    assert property ($fell(o_power_good_out_oe) |-> $past(i_soft_start_done)
        && $past(i_voltage_id_code) != 8'h00 && $past(i_output_sense_ref) >= lo_ff
        && $past(i_output_sense_ref) <= hi_ff) else $error("power good rose wrongly");
    a_ilim_normal:
    assert property (o_shed_phase_disable_n |-> o_ilim_div == 3'h1) else $error("divisor");
    a_start_gate:
    assert property ($rose(o_main_phase_disable_n) |-> $past(run, 2)) else $error("early start");
    c_pg_up: cover property ($fell(o_power_good_out_oe));
    c_trip: cover property ($rose(o_pwm_force_low));
    c_shed: cover property ($fell(o_shed_phase_disable_n));
endmodule // pgps_checker
bind pgps_top pgps_checker chk_u (.i_clk, .i_nrst, .i_ce, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
    .i_undervoltage_lockout_ok, .i_enable, .i_low_power_state_n, .i_soft_start_done,
    .i_below_release, .i_output_sense_ref, .i_voltage_id_code, .o_power_good_out_oe,
    .o_pwm_force_low, .o_shed_phase_disable_n, .o_main_phase_disable_n, .o_ilim_div);
`default_nettype wire

// [testbench/power_good_phase_shed_protect_tb_top.sv]
// Self-checking bench of the supervisor
`timescale 1ns/1ps
`default_nettype none
module power_good_phase_shed_protect_tb_top;
    localparam int STEP = 20;
    logic clk, nrst, wr, rd, undervoltage_lockout, en, lp_n, ss, below, oe, pgo, fl, shed_n, main_n, pgw;
    logic [7:0] addr, wdata, sense, voltage_id_code, rdata, act;
    logic [2:0] div;
    int num_errors = 0;
    int n_checks = 0;
    logic [7:0] ra [6] = '{8'h03, 8'hD4, 8'hE8, 8'hE9, 8'hEA, 8'h55};
    logic [7:0] rv [6] = '{8'h00, 8'h03, 8'hC0, 8'h40, 8'h07, 8'h00};
    logic [7:0] dc [2] = '{8'h00, 8'h07};
    pgps_top #(.DELAY_STEP_CYC(STEP)) dut_u (.i_clk(clk), .i_nrst(nrst), .i_ce(1'b1),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .i_undervoltage_lockout_ok(undervoltage_lockout), .i_enable(en),
        .i_low_power_state_n(lp_n), .i_soft_start_done(ss), .i_below_release(below),
        .i_output_sense_ref(sense), .i_voltage_id_code(voltage_id_code), .i_power_good_in(pgw),
        .o_power_good_out(pgo), .o_power_good_out_oe(oe), .o_pwm_force_low(fl),
        .o_shed_phase_disable_n(shed_n), .o_main_phase_disable_n(main_n),
        .o_phase_active(act), .o_ilim_div(div));
    pgps_drv_model drv_u (.i_pg_oe(oe), .o_pg_wire(pgw));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic results;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("reg", rdata, e);
    endtask
    task automatic wait_pg(output int n);
        for (n = 0; oe !== 1'b0 && n < 400; n++)
            @(posedge clk) #1;
        if (n == 400)
        begin
            num_errors++;
            results();
        end
    endtask
    // Expected {divisor, running phases} in the low-power state
    function automatic logic [10:0] exp_lp(input int n, input int c);
        if (n == 8)
            return c == 0 ? {3'h4, 8'h01} : c == 1 ? {3'h4, 8'h11} : {3'h2, 8'h55};
        if (n == 6)
            return c == 0 ? {3'h4, 8'h01} : c == 1 ? {3'h3, 8'h09} : {3'h2, 8'h15};
        if (c == 0 || (n == 7 && c == 1))
            return {n > 4 ? 3'h4 : 3'(n), 8'h01};
        return {n == 1 ? 3'h1 : 3'h2, 8'h01};
    endfunction
    task automatic sense_chk(input logic [7:0] s, input string nm, input logic [3:0] e);
        sense <= s;
        cyc(6);
        chk(nm, {oe, fl, shed_n, main_n}, e);
    endtask
    initial
    begin
        int n;
        {nrst, wr, rd, undervoltage_lockout, en, ss, lp_n, below} = 8'h03;
        {addr, wdata, sense, voltage_id_code} = 32'h0000_8010;
        cyc(12);
        nrst <= 1'b1;
        foreach (ra[i])
            rd_chk(ra[i], rv[i]);
        foreach (dc[i])
        begin
            wr_reg(8'hD4, dc[i]);
            en <= 1'b1;
            cyc(10);
            chk("start gate", main_n, 0);
            undervoltage_lockout <= 1'b1;
            cyc(40);
            chk("pg before ss", oe, 1);
            ss <= 1'b1;
            wait_pg(n);
            chk("delay", n >= dc[i] * STEP + 22 && n <= dc[i] * STEP + 28, 1);
            chk("pg wire", pgw, 1);
            chk("pg data", pgo, 0);
            undervoltage_lockout <= 1'b0;
            ss <= 1'b0;
            cyc(6);
            chk("off", {oe, fl, shed_n, main_n}, 4'hC);
        end
        undervoltage_lockout <= 1'b1;
        ss <= 1'b1;
        wait_pg(n);
        for (int p = 1; p <= 8; p++)
            for (int c = 0; c < 4; c++)
            begin
                wr_reg(8'hEA, 8'(p - 1));
                wr_reg(8'h03, 8'(c << 6));
                lp_n <= 1'b0;
                cyc(6);
                chk("low power", {shed_n, div, act}, exp_lp(p, c));
                lp_n <= 1'b1;
                cyc(6);
                chk("normal", {shed_n, div, act}, {4'h9, 8'hFF >> (8 - p)});
            end
        sense_chk(8'h3F, "below low", 4'hB);
        sense_chk(8'h40, "at low", 4'h3);
        cyc(4200);
        below <= 1'b0;
        sense_chk(8'hD0, "trip", 4'hF);
        sense_chk(8'h80, "latched", 4'h7);
        rd_chk(8'hEB, 8'hE8);
        below <= 1'b1;
        sense_chk(8'h80, "released", 4'h3);
        wr_reg(8'hE8, 8'hE0);
        below <= 1'b0;
        sense_chk(8'hD0, "moved limit", 4'h3);
        sense_chk(8'hE1, "moved trip", 4'hF);
        below <= 1'b1;
        sense_chk(8'h80, "back", 4'h3);
        voltage_id_code <= 8'h12;
        cyc(6);
        sense_chk(8'h20, "blanked", 4'h3);
        voltage_id_code <= 8'h13;
        cyc(3995);
        chk("reblanked", oe, 0);
        cyc(150);
        chk("blank over", oe, 1);
        voltage_id_code <= 8'h00;
        sense_chk(8'h80, "no cpu", 4'hB);
        en <= 1'b0;
        sense_chk(8'h80, "enable low", 4'hC);
        results();
    end
endmodule // power_good_phase_shed_protect_tb_top
`default_nettype wire
